// file: dcs_pkg.sv
// Constants shared by the option-strap decode block
package dcs_pkg;

    // ----------
    // Host option switch pack bit positions (switch n sits at bit n-1)
    // ----------
    localparam int HOST_HOLD_BIT     = 0;
    localparam int HOST_STALL_BIT    = 2;
    localparam int HOST_DEC_SEL_BIT  = 3;
    localparam int HOST_BASE_LSB     = 4;
    localparam int HOST_WIDTH        = 8;

    // ----------
    // Drive configuration and feature switch pack bit positions
    // ----------
    localparam int CFG_CODE_LSB      = 0;
    localparam int CFG_CODE_WIDTH    = 6;
    localparam int CFG_EIGHT_BIT     = 6;
    localparam int CFG_WIDTH         = 10;
    localparam int FEAT_BOARD_BIT    = 0;
    localparam int FEAT_ILEAVE_BIT   = 2;
    localparam int FEAT_SWAP_BIT     = 3;
    localparam int FEAT_REPL_BIT     = 4;
    localparam int FEAT_CABLE_A_BIT  = 7;
    localparam int FEAT_SPMAP_BIT    = 8;
    localparam int FEAT_WIDTH        = 10;
    localparam int VEC_WIDTH         = 8;

    // ----------
    // Host base addresses of the primary decode table (18-bit octal)
    // ----------
    localparam logic [17:0] PRI_BASE_0 = 18'o776700;
    localparam logic [17:0] PRI_BASE_1 = 18'o776300;
    localparam logic [17:0] PRI_BASE_2 = 18'o776600;
    localparam logic [17:0] PRI_BASE_3 = 18'o776400;
    localparam int          BASE_WIN_LSB = 6;    // 64-byte register window

    // ----------
    // Drive geometry table entries
    // ----------
    localparam logic [5:0]  CODE_NSTD_PAIR = 6'h0a;
    localparam logic [5:0]  CODE_EXP_A     = 6'h03;
    localparam logic [5:0]  CODE_EXP_B     = 6'h04;
    localparam logic [10:0] NSTD_CYL       = 11'd815;
    localparam logic [5:0]  NSTD_TRK       = 6'd19;
    localparam logic [6:0]  NSTD_SEC       = 7'd32;
    localparam logic [10:0] EXP_CYL        = 11'd842;
    localparam logic [5:0]  EXP_TRK        = 6'd20;
    localparam logic [6:0]  EXP_SEC        = 7'd44;

    // ----------
    // Register port map and reset values
    // ----------
    localparam logic [7:0]  REG_CTRL   = 8'h00;
    localparam logic [7:0]  REG_OPTS   = 8'h04;
    localparam logic [7:0]  REG_BASE   = 8'h08;
    localparam logic [7:0]  REG_VECT   = 8'h0c;
    localparam logic [7:0]  REG_GEOM   = 8'h10;
    localparam int          CTRL_RELATCH_BIT = 0;
    localparam logic [31:0] RD_ZERO    = 32'h0000_0000;

    // Settle countdown start; synchronised switches are taken on the fifth clock after reset release
    localparam logic [1:0]  SETTLE_CYCLES = 2'h3;

    // Capture sequencer states
    typedef enum logic [2:0] {
        DCS_ST_FROZEN = 3'b001,
        DCS_ST_SETTLE = 3'b010,
        DCS_ST_RUN    = 3'b100
    } dcs_state_t;

endpackage : dcs_pkg

// file: dcs_sync.sv
// Two-flop synchroniser for a bundle of static switch levels
`timescale 1ns/1ps
module dcs_sync #(
    parameter int WIDTH = 8
) (
    input  wire logic             i_clk,
    input  wire logic             i_rst_b,
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta_q;

    // First stage feeds only the second stage
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            meta_q <= '0;
            o_sync <= '0;
        end else begin
            meta_q <= i_async;
            o_sync <= meta_q;
        end
    end
endmodule : dcs_sync

// file: dcs_geom.sv
// Drive configuration code to emulated geometry lookup
`timescale 1ns/1ps
module dcs_geom (
    input  wire logic [5:0]  i_code,
    input  wire logic        i_eight,
    output logic      [10:0] o_cyl,
    output logic      [5:0]  o_trk,
    output logic      [6:0]  o_sec,
    output logic             o_rp_emul
);
    // Known table entries; others report zero geometry
    always_comb begin
        o_cyl     = '0;
        o_trk     = '0;
        o_sec     = '0;
        o_rp_emul = 1'b0;
        if (i_code == dcs_pkg::CODE_NSTD_PAIR) begin
            // RQ17 nonstandard pair geometry
            o_cyl = dcs_pkg::NSTD_CYL;
            o_trk = dcs_pkg::NSTD_TRK;
            o_sec = dcs_pkg::NSTD_SEC;
        end else if (i_code == dcs_pkg::CODE_EXP_A ||
                     (i_code == dcs_pkg::CODE_EXP_B && !i_eight)) begin
            // RQ18 expanded RP-family geometry
            o_cyl     = dcs_pkg::EXP_CYL;
            o_trk     = dcs_pkg::EXP_TRK;
            o_sec     = dcs_pkg::EXP_SEC;
            o_rp_emul = 1'b1;
        end
    end
endmodule : dcs_geom

// file: dcs_strap_decode.sv
// Option-strap decode for the multi-port disk controller
//
// What this block does
// RQ1 - Hold switch on freezes controller in reset; no CPU access answered.
// RQ2 - Stall enabled: PIO during DMA raises a non-processor bus request.
// RQ3 - Installer keeps the stall circuit enabled except for odd hardware.
// RQ4 - Six-bit code picks drive configuration; another switch picks 4 or 8 drives.
// RQ5 - Board switch on means eight-port board, off means four-port board.
// RQ6 - A switch enables two-to-one hardware sector interleave.
// RQ7 - Swap option exchanges logical units 0-3 with units 4-7.
// RQ8 - Replacement track mode switch; acts only for RP-family emulation.
// RQ9 - Cable switch on takes index and sector from A cable, else B cables.
// RQ10 - Special alternative mapping switch for RP-family emulation.
// RQ11 - Decode-select open uses primary table, closed uses alternate table.
// RQ12 - Four base switches each select one of four base addresses.
// RQ13 - Installer closes exactly one base switch, else several ranges answer.
// RQ14 - Vector switches give vector bits 1-8, switch n to bit n, bit 0 zero.
// RQ15 - Closed switch yields one in its vector bit, open yields zero.
// RQ16 - Standard vector: bit 8 off, bit 7 on, bit 6 off.
// RQ17 - Pair 0A/0AA presents 815 cylinders, 19 tracks, 32 sectors.
// RQ18 - Expanded RP configurations present 842 cylinders, 20 tracks, 44 sectors.
// RQ19 - Replacement mode, good CRC, nonzero word 4: take cylinder and track.
// RQ20 - Switches are static, synchronised, and latched after reset release.
`timescale 1ns/1ps
module dcs_strap_decode #(
    parameter logic [17:0] ALT_BASE_0 = 18'o770000,   // Alternate table, arbitrary
    parameter logic [17:0] ALT_BASE_1 = 18'o770100,
    parameter logic [17:0] ALT_BASE_2 = 18'o770200,
    parameter logic [17:0] ALT_BASE_3 = 18'o770300
) (
    input  wire logic        i_clk,
    input  wire logic        i_rst_b,
    // Switch packs
    input  wire logic [7:0]  i_host_option_switch_pack,
    input  wire logic [7:0]  i_vector_switch_pack,
    input  wire logic [9:0]  i_drive_config_switch_pack,
    input  wire logic [9:0]  i_feature_switch_pack,
    // Host bus side
    input  wire logic [17:0] i_host_addr,
    input  wire logic        i_pio_req,
    input  wire logic        i_dma_busy,
    input  wire logic [2:0]  i_log_unit,
    // Header words from the drive side
    input  wire logic        i_hdr_valid,
    input  wire logic        i_hdr_crc_ok,
    input  wire logic [15:0] i_hdr_w3,
    input  wire logic [15:0] i_hdr_w4,
    // Register port
    input  wire logic [7:0]  i_reg_addr,
    input  wire logic [31:0] i_reg_wdata,
    input  wire logic        i_reg_wr,
    input  wire logic        i_reg_rd,
    output logic      [31:0] o_reg_rdata,
    // Decoded settings
    output logic             o_ctrl_run,
    output logic             o_npr_req,
    output logic             o_addr_match,
    output logic [3:0]       o_base_hit,
    output logic [8:0]       o_vector,
    output logic [5:0]       o_cfg_code,
    output logic             o_eight_drive,
    output logic             o_eight_port,
    output logic             o_interleave,
    output logic             o_cable_a,
    output logic             o_repl_mode,
    output logic             o_special_map,
    output logic [2:0]       o_phys_unit,
    output logic [10:0]      o_geom_cyl,
    output logic [5:0]       o_geom_trk,
    output logic [6:0]       o_geom_sec,
    output logic             o_repl_valid,
    output logic [15:0]      o_repl_cyl,
    output logic [7:0]       o_repl_trk,
    output logic             o_repl_steer
);

    // ----------
    // Switch synchronisers
    // ----------
    logic [7:0]  host_s;
    logic [7:0]  vec_s;
    logic [9:0]  cfg_s;
    logic [9:0]  feat_s;

    // RQ20 synchronise switches
    dcs_sync #(.WIDTH(dcs_pkg::HOST_WIDTH)) u_sync_host (
        .i_clk   (i_clk),
        .i_rst_b (i_rst_b),
        .i_async (i_host_option_switch_pack),
        .o_sync  (host_s)
    );
    dcs_sync #(.WIDTH(dcs_pkg::VEC_WIDTH)) u_sync_vec (
        .i_clk   (i_clk),
        .i_rst_b (i_rst_b),
        .i_async (i_vector_switch_pack),
        .o_sync  (vec_s)
    );
    dcs_sync #(.WIDTH(dcs_pkg::CFG_WIDTH)) u_sync_cfg (
        .i_clk   (i_clk),
        .i_rst_b (i_rst_b),
        .i_async (i_drive_config_switch_pack),
        .o_sync  (cfg_s)
    );
    dcs_sync #(.WIDTH(dcs_pkg::FEAT_WIDTH)) u_sync_feat (
        .i_clk   (i_clk),
        .i_rst_b (i_rst_b),
        .i_async (i_feature_switch_pack),
        .o_sync  (feat_s)
    );

    // ----------
    // Freeze and capture sequencer
    // ----------
    dcs_pkg::dcs_state_t state_q;
    logic [1:0]          settle_q;
    logic                relatch_q;
    logic                hold;
    logic                capture;
    logic                run;

    assign hold    = host_s[dcs_pkg::HOST_HOLD_BIT];
    assign run     = (state_q == dcs_pkg::DCS_ST_RUN);
    assign capture = (state_q == dcs_pkg::DCS_ST_SETTLE && settle_q == '0) ||
                     (run && relatch_q);

    // RQ1 hold switch freezes the controller
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_q  <= dcs_pkg::DCS_ST_FROZEN;
            settle_q <= dcs_pkg::SETTLE_CYCLES;
        end else if (hold) begin
            state_q  <= dcs_pkg::DCS_ST_FROZEN;
            settle_q <= dcs_pkg::SETTLE_CYCLES;
        end else begin
            case (state_q)
                dcs_pkg::DCS_ST_FROZEN: begin
                    state_q <= dcs_pkg::DCS_ST_SETTLE;
                end
                dcs_pkg::DCS_ST_SETTLE: begin
                    settle_q <= settle_q - 2'h1;
                    if (settle_q == '0) begin
                        state_q <= dcs_pkg::DCS_ST_RUN;
                    end
                end
                dcs_pkg::DCS_ST_RUN: begin
                    state_q <= dcs_pkg::DCS_ST_RUN;
                end
                default: begin
                    state_q <= dcs_pkg::DCS_ST_FROZEN;
                end
            endcase
        end
    end

    // Run indication to the rest of the controller
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_ctrl_run <= 1'b0;
        end else begin
            o_ctrl_run <= run && !hold;
        end
    end

    // ----------
    // Latched option settings
    // ----------
    logic        stall_en_q;
    logic        alt_sel_q;
    logic        rp_emul_q;
    logic        swap_q;
    logic        repl_sw_q;
    logic        spmap_sw_q;
    logic [10:0] g_cyl;
    logic [5:0]  g_trk;
    logic [6:0]  g_sec;
    logic        g_rp;

    // RQ4 configuration lookup
    dcs_geom u_geom (
        .i_code    (cfg_s[dcs_pkg::CFG_CODE_LSB +: dcs_pkg::CFG_CODE_WIDTH]),
        .i_eight   (cfg_s[dcs_pkg::CFG_EIGHT_BIT]),
        .o_cyl     (g_cyl),
        .o_trk     (g_trk),
        .o_sec     (g_sec),
        .o_rp_emul (g_rp)
    );

    // RQ20 latch decoded settings once settled
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            stall_en_q    <= 1'b0;
            alt_sel_q     <= 1'b0;
            o_base_hit    <= '0;
            o_vector      <= '0;
            o_cfg_code    <= '0;
            o_eight_drive <= 1'b0;
            o_geom_cyl    <= '0;
            o_geom_trk    <= '0;
            o_geom_sec    <= '0;
            rp_emul_q     <= 1'b0;
        end else if (capture) begin
            stall_en_q    <= host_s[dcs_pkg::HOST_STALL_BIT];
            // RQ11 decode table select
            alt_sel_q     <= host_s[dcs_pkg::HOST_DEC_SEL_BIT];
            // RQ12 base range switches, several may be closed
            o_base_hit    <= host_s[dcs_pkg::HOST_BASE_LSB +: 4];
            // RQ14 RQ15 RQ16 switch n drives vector bit n
            o_vector      <= {vec_s, 1'b0};
            o_cfg_code    <= cfg_s[dcs_pkg::CFG_CODE_LSB +: dcs_pkg::CFG_CODE_WIDTH];
            // RQ4 four or eight drive mode
            o_eight_drive <= cfg_s[dcs_pkg::CFG_EIGHT_BIT];
            o_geom_cyl    <= g_cyl;
            o_geom_trk    <= g_trk;
            o_geom_sec    <= g_sec;
            rp_emul_q     <= g_rp;
        end
    end

    // Feature switches latched with the same capture
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_eight_port  <= 1'b0;
            o_interleave  <= 1'b0;
            o_cable_a     <= 1'b0;
            swap_q        <= 1'b0;
            repl_sw_q     <= 1'b0;
            spmap_sw_q    <= 1'b0;
        end else if (capture) begin
            // RQ5 board type
            o_eight_port  <= feat_s[dcs_pkg::FEAT_BOARD_BIT];
            // RQ6 sector interleave
            o_interleave  <= feat_s[dcs_pkg::FEAT_ILEAVE_BIT];
            // RQ9 index and sector cable select
            o_cable_a     <= feat_s[dcs_pkg::FEAT_CABLE_A_BIT];
            swap_q        <= feat_s[dcs_pkg::FEAT_SWAP_BIT];
            repl_sw_q     <= feat_s[dcs_pkg::FEAT_REPL_BIT];
            spmap_sw_q    <= feat_s[dcs_pkg::FEAT_SPMAP_BIT];
        end
    end

    // RQ8 RQ10 RP-only modes gated by emulation type
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_repl_mode   <= 1'b0;
            o_special_map <= 1'b0;
        end else begin
            o_repl_mode   <= repl_sw_q && rp_emul_q;
            o_special_map <= spmap_sw_q && rp_emul_q;
        end
    end

    // ----------
    // Host-side live decode
    // ----------
    logic [17:0] base_tab [4];
    logic        any_hit;

    // RQ11 primary or alternate table
    assign base_tab[0] = alt_sel_q ? ALT_BASE_0 : dcs_pkg::PRI_BASE_0;
    assign base_tab[1] = alt_sel_q ? ALT_BASE_1 : dcs_pkg::PRI_BASE_1;
    assign base_tab[2] = alt_sel_q ? ALT_BASE_2 : dcs_pkg::PRI_BASE_2;
    assign base_tab[3] = alt_sel_q ? ALT_BASE_3 : dcs_pkg::PRI_BASE_3;

    // RQ13 every closed base switch answers its range
    always_comb begin
        any_hit = 1'b0;
        for (int i = 0; i < 4; i++) begin
            if (o_base_hit[i] &&
                i_host_addr[17:dcs_pkg::BASE_WIN_LSB] ==
                base_tab[i][17:dcs_pkg::BASE_WIN_LSB]) begin
                any_hit = 1'b1;
            end
        end
    end

    // RQ1 no response while frozen; RQ2 stall CPU during DMA
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_addr_match <= 1'b0;
            o_npr_req    <= 1'b0;
        end else begin
            o_addr_match <= run && any_hit;
            o_npr_req    <= run && stall_en_q && i_pio_req && i_dma_busy;
        end
    end

    // RQ7 swap logical unit halves
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_phys_unit <= '0;
        end else begin
            o_phys_unit <= {i_log_unit[2] ^ swap_q, i_log_unit[1:0]};
        end
    end

    // ----------
    // Replacement track header capture
    // ----------
    // RQ19 take replacement address from header words 3 and 4
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_repl_valid <= 1'b0;
            o_repl_cyl   <= '0;
            o_repl_trk   <= '0;
            o_repl_steer <= 1'b0;
        end else begin
            o_repl_valid <= 1'b0;
            if (run && o_repl_mode && i_hdr_valid && i_hdr_crc_ok &&
                i_hdr_w4 != 16'h0000) begin
                o_repl_valid <= 1'b1;
                o_repl_cyl   <= i_hdr_w3;
                o_repl_trk   <= i_hdr_w4[7:0];
                o_repl_steer <= i_hdr_w4[8];
            end
        end
    end

    // ----------
    // Register port
    // ----------
    // Relatch request: one-cycle pulse from a control write
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            relatch_q <= 1'b0;
        end else begin
            relatch_q <= run && i_reg_wr && i_reg_addr == dcs_pkg::REG_CTRL &&
                         i_reg_wdata[dcs_pkg::CTRL_RELATCH_BIT];
        end
    end

    // RQ1 reads answer zero while frozen
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_reg_rdata <= dcs_pkg::RD_ZERO;
        end else if (i_reg_rd && run) begin
            case (i_reg_addr)
                dcs_pkg::REG_OPTS: o_reg_rdata <= {16'h0000, o_cfg_code,
                    o_eight_drive, o_eight_port, o_interleave, swap_q,
                    o_repl_mode, o_cable_a, o_special_map, stall_en_q,
                    alt_sel_q, rp_emul_q};
                dcs_pkg::REG_BASE: o_reg_rdata <= {24'h00_0000, 3'h0, alt_sel_q,
                    o_base_hit};
                dcs_pkg::REG_VECT: o_reg_rdata <= {23'h00_0000, o_vector};
                dcs_pkg::REG_GEOM: o_reg_rdata <= {8'h00, o_geom_cyl, o_geom_trk,
                    o_geom_sec};
                default:           o_reg_rdata <= dcs_pkg::RD_ZERO;
            endcase
        end else begin
            o_reg_rdata <= dcs_pkg::RD_ZERO;
        end
    end

endmodule : dcs_strap_decode

// file: dcs_strap_decode_checker.sv
// Concurrent checks on the ports of the option-strap decode block
`timescale 1ns/1ps
module dcs_strap_decode_checker (
    input wire logic        i_clk,
    input wire logic        i_rst_b,
    input wire logic [7:0]  i_host_option_switch_pack,
    input wire logic [7:0]  i_vector_switch_pack,
    input wire logic [9:0]  i_feature_switch_pack,
    input wire logic [17:0] i_host_addr,
    input wire logic        i_pio_req,
    input wire logic        i_dma_busy,
    input wire logic [2:0]  i_log_unit,
    input wire logic        i_hdr_valid,
    input wire logic        i_hdr_crc_ok,
    input wire logic [15:0] i_hdr_w4,
    input wire logic [31:0] o_reg_rdata,
    input wire logic        o_ctrl_run,
    input wire logic        o_npr_req,
    input wire logic        o_addr_match,
    input wire logic [8:0]  o_vector,
    input wire logic [5:0]  o_cfg_code,
    input wire logic        o_repl_mode,
    input wire logic        o_special_map,
    input wire logic [2:0]  o_phys_unit,
    input wire logic [10:0] o_geom_cyl,
    input wire logic        o_repl_valid
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    // ----------
    // Properties
    // ----------
    AST_FROZEN_QUIET: assert property (!o_ctrl_run && !$past(o_ctrl_run) |->
        !o_npr_req && !o_addr_match && o_reg_rdata == 32'h0)
        else $error("frozen reply");
    AST_NPR_CAUSE: assert property (o_ctrl_run && $past(o_ctrl_run) |->
        o_npr_req == ($past(i_pio_req && i_dma_busy) && i_host_option_switch_pack[2]))
        else $error("stall wrong");
    AST_ADDR_PRI: assert property (o_ctrl_run && $past(o_ctrl_run)
        && i_host_option_switch_pack[7:3] == 5'b00010
        |-> o_addr_match == ($past(i_host_addr[17:6]) == 12'o7767))
        else $error("base decode");
    AST_VEC: assert property (o_ctrl_run |-> o_vector == {i_vector_switch_pack, 1'b0})
        else $error("vector wrong");
    AST_VEC_ZERO: assert property (o_vector[0] == 1'b0)
        else $error("vector bit 0");
    AST_SWAP: assert property (o_ctrl_run && $past(o_ctrl_run) |-> o_phys_unit ==
        {$past(i_log_unit[2]) ^ i_feature_switch_pack[3], $past(i_log_unit[1:0])})
        else $error("unit map");
    AST_REPL_CAUSE: assert property (o_repl_valid |-> $past(i_hdr_valid && i_hdr_crc_ok
        && i_hdr_w4 != 16'h0 && o_repl_mode) ##1 !o_repl_valid)
        else $error("repl pulse");
    AST_REPL_RP: assert property (o_repl_mode || o_special_map |-> o_geom_cyl == 11'd842)
        else $error("rp-only mode");
    AST_GEOM_NSTD: assert property (o_ctrl_run && o_cfg_code == 6'h0a
        |-> o_geom_cyl == 11'd815 && !o_repl_mode)
        else $error("pair geometry");
    COV_NPR: cover property (o_npr_req);
    COV_MATCH: cover property (o_addr_match);
    COV_REPL: cover property (o_repl_valid);
endmodule : dcs_strap_decode_checker

bind dcs_strap_decode dcs_strap_decode_checker chk_u (.*);

// file: dcs_host_model.sv
// Host processor model issuing programmed accesses on the system bus
`timescale 1ns/1ps
module dcs_host_model (
    input  wire logic        i_clk,
    input  wire logic        i_go,
    input  wire logic [17:0] i_addr,
    input  wire logic [3:0]  i_len,
    output logic      [17:0] o_host_addr,
    output logic             o_pio_req
);
    logic [3:0] cnt_q = 4'h0;
    initial o_pio_req = 1'b0;
    initial o_host_addr = 18'h0;
    // ----------
    // Access held i_len cycles; a released bus toggles, never stale
    // ----------
    always @(posedge i_clk) begin
        if (i_go) begin
            cnt_q       <= i_len;
            o_pio_req   <= 1'b1;
            o_host_addr <= i_addr;
        end else if (cnt_q > 4'h1) begin
            cnt_q <= cnt_q - 4'h1;
        end else begin
            cnt_q       <= 4'h0;
            o_pio_req   <= 1'b0;
            o_host_addr <= ~o_host_addr;
        end
    end
endmodule : dcs_host_model

// file: test_dcs_strap_decode.sv
// Self-checking testbench of the option-strap decode block
`timescale 1ns/1ps
module test_dcs_strap_decode;
    localparam logic [17:0] ALT0 = 18'o770000;
    logic i_clk = 0, i_rst_b = 0, i_pio_req, i_dma_busy = 0, go = 0;
    logic [7:0] i_host_option_switch_pack = 8'h14, i_vector_switch_pack = 0;
    logic [9:0] i_drive_config_switch_pack = 0, i_feature_switch_pack = 0;
    logic [17:0] i_host_addr, gaddr = 0;
    logic [3:0] glen = 0;
    logic [2:0] i_log_unit = 0;
    logic i_hdr_valid = 0, i_hdr_crc_ok = 0, i_reg_wr = 0, i_reg_rd = 0;
    logic [15:0] i_hdr_w3 = 0, i_hdr_w4 = 0;
    logic [7:0] i_reg_addr = 0;
    logic [31:0] i_reg_wdata = 0, o_reg_rdata;
    logic o_ctrl_run, o_npr_req, o_addr_match, o_eight_drive, o_eight_port, o_interleave;
    logic o_cable_a, o_repl_mode, o_special_map, o_repl_valid, o_repl_steer;
    logic [3:0] o_base_hit;
    logic [8:0] o_vector;
    logic [5:0] o_cfg_code, o_geom_trk;
    logic [2:0] o_phys_unit;
    logic [10:0] o_geom_cyl;
    logic [6:0] o_geom_sec;
    logic [15:0] o_repl_cyl;
    logic [7:0] o_repl_trk;
    int mismatches = 0, n_checks = 0;

    always #4 i_clk = ~i_clk;
    dcs_strap_decode #(.ALT_BASE_0(ALT0)) dut_u (.*);
    dcs_host_model host_u (.i_clk(i_clk), .i_go(go), .i_addr(gaddr), .i_len(glen),
                           .o_host_addr(i_host_addr), .o_pio_req(i_pio_req));

    // ----------
    // Shared tasks
    // ----------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic boot(input logic [7:0] h, input logic [7:0] v, input logic [9:0] c,
                        input logic [9:0] f);
        @(posedge i_clk);
        i_rst_b                    <= 1'b0;
        i_host_option_switch_pack  <= h;
        i_vector_switch_pack       <= v;
        i_drive_config_switch_pack <= c;
        i_feature_switch_pack      <= f;
        repeat (5) @(posedge i_clk);
        i_rst_b <= 1'b1;
        repeat (8) @(posedge i_clk);
        #1;
        chk(o_ctrl_run, 1);
    endtask : boot
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge i_clk);
        i_reg_addr <= a;
        i_reg_rd   <= 1'b1;
        @(posedge i_clk);
        i_reg_rd <= 1'b0;
        #1;
        d = o_reg_rdata;
    endtask : rd
    task automatic acc(input logic [17:0] a, input logic dm, output logic [1:0] r);
        @(posedge i_clk);
        go         <= 1'b1;
        gaddr      <= a;
        glen       <= 4'h3;
        i_dma_busy <= dm;
        @(posedge i_clk);
        go <= 1'b0;
        @(posedge i_clk);
        #1;
        r = {o_npr_req, o_addr_match};
        repeat (4) @(posedge i_clk);
    endtask : acc
    task automatic hdr(input logic ok, input logic [15:0] w4, output logic [25:0] r);
        @(posedge i_clk);
        i_hdr_valid  <= 1'b1;
        i_hdr_crc_ok <= ok;
        i_hdr_w3     <= 16'h0345;
        i_hdr_w4     <= w4;
        @(posedge i_clk);
        i_hdr_valid <= 1'b0;
        #1;
        r = {o_repl_valid, o_repl_steer, o_repl_trk, o_repl_cyl};
    endtask : hdr

    // ----------
    // Scenarios
    // ----------
    task automatic t_vec;
        logic [8:0] tbl [4] = '{9'o150, 9'o354, 9'o270, 9'o254};
        logic [31:0] d;
        foreach (tbl[k]) begin
            boot(8'h14, tbl[k][8:1], 10'h0, 10'h0);
            rd(dcs_pkg::REG_VECT, d);
            chk(d, {23'h0, tbl[k]});
        end
        chk(o_vector[8:6], 3'h2);
        rd(8'h14, d);
        chk(d, 0);
        @(posedge i_clk);
        i_reg_wr   <= 1'b1;
        i_reg_addr <= dcs_pkg::REG_CTRL;
        i_reg_wdata <= 32'h1;
        @(posedge i_clk);
        i_reg_wr <= 1'b0;
        repeat (4) @(posedge i_clk);
        #1;
        chk({o_ctrl_run, o_vector}, {1'b1, 9'o254});
        @(posedge i_clk);
        i_host_option_switch_pack <= 8'h15;
        repeat (6) @(posedge i_clk);
        #1;
        chk(o_ctrl_run, 0);
        rd(dcs_pkg::REG_VECT, d);
        chk(d, 0);
        @(posedge i_clk);
        i_host_option_switch_pack <= 8'h14;
        repeat (10) @(posedge i_clk);
        #1;
        chk(o_ctrl_run, 1);
        $display("test vector and hold done");
    endtask : t_vec
    task automatic t_base;
        logic [17:0] b [4] = '{dcs_pkg::PRI_BASE_0, dcs_pkg::PRI_BASE_1,
                               dcs_pkg::PRI_BASE_2, dcs_pkg::PRI_BASE_3};
        logic [1:0] r;
        for (int k = 0; k < 4; k++) begin
            boot(8'h04 | (8'h10 << k), 8'h56, 10'h0, 10'h0);
            chk(o_base_hit, 4'h1 << k);
            acc(b[k] + 18'h2, 1'b1, r);
            chk(r, 2'b11);
            acc(b[(k + 1) % 4], 1'b0, r);
            chk(r, 2'b00);
        end
        boot(8'h1c, 8'h56, 10'h0, 10'h0);
        acc(ALT0, 1'b0, r);
        chk(r, 2'b01);
        acc(b[0], 1'b1, r);
        chk(r, 2'b10);
        boot(8'h10, 8'h56, 10'h0, 10'h0);
        acc(b[0], 1'b1, r);
        chk(r, 2'b01);
        $display("test base and stall done");
    endtask : t_base
    task automatic t_feat;
        logic [25:0] r;
        boot(8'h14, 8'h56, 10'h04a, 10'h19d);
        chk({o_cfg_code, o_eight_drive, o_eight_port, o_interleave, o_cable_a},
            {6'h0a, 4'hf});
        chk({o_geom_cyl, o_geom_trk, o_geom_sec}, {11'd815, 6'd19, 7'd32});
        chk({o_repl_mode, o_special_map}, 2'b00);
        for (int u = 0; u < 8; u++) begin
            @(posedge i_clk);
            i_log_unit <= u[2:0];
            @(posedge i_clk);
            #1;
            chk(o_phys_unit, u[2:0] ^ 3'h4);
        end
        boot(8'h14, 8'h56, 10'h003, 10'h110);
        chk({o_geom_cyl, o_geom_trk, o_geom_sec}, {11'd842, 6'd20, 7'd44});
        chk({o_repl_mode, o_special_map, o_eight_port, o_cable_a}, 4'hc);
        chk(o_phys_unit, 3'h7);
        hdr(1'b1, 16'h01a7, r);
        chk(r, {2'b11, 8'ha7, 16'h0345});
        hdr(1'b0, 16'h0022, r);
        chk(r, {2'b01, 8'ha7, 16'h0345});
        hdr(1'b1, 16'h0000, r);
        chk(r[25], 0);
        $display("test features done");
    endtask : t_feat
    task automatic finish_test;
        $display("checks=%0d mismatches=%0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : finish_test

    initial begin
        t_vec();
        t_base();
        t_feat();
        finish_test();
    end
    initial begin
        #200000;
        mismatches++;
        finish_test();
    end
endmodule : test_dcs_strap_decode
